// ---- rtl/ccm_pkg.sv ----
// Purpose: shared constants for the clock monitor and dual clock comparators
// Assumes: all monitored clocks arrive as pins sampled by the 50 MHz system clock
// Notes: source codes and keys are the documented encodings
// ==========================================================================
// clock monitor package
package ccm_pkg;
	// system clock rate
	localparam int unsigned CCM_SYS_HZ = 50000000;
	// default seed width and detector window length (in internal osc edges)
	localparam int unsigned CCM_SEED_W = 16;
	localparam int unsigned CCM_DET_WIN = 16;
	localparam int unsigned CCM_DET_CW = 8;
	// valid window factor: f_int/4 < f_osc < f_int*4
	localparam int unsigned CCM_WIN_FACTOR = 4;
	// sampled-clock vector positions
	localparam int unsigned CCM_NSRC = 10;
	localparam logic [3:0] SRC_OSC = 4'h0;
	localparam logic [3:0] SRC_HF = 4'h1;
	localparam logic [3:0] SRC_LF = 4'h2;
	localparam logic [3:0] SRC_TCK = 4'h3;
	localparam logic [3:0] SRC_PLL = 4'h4;
	localparam logic [3:0] SRC_EXT1 = 4'h5;
	localparam logic [3:0] SRC_EXT2 = 4'h6;
	localparam logic [3:0] SRC_PER = 4'h7;
	localparam logic [3:0] SRC_TM1 = 4'h8;
	localparam logic [3:0] SRC_TM2 = 4'h9;
	localparam logic [3:0] SRC_NONE = 4'hF;
	// source field and key encodings
	localparam logic [3:0] KEY_ENABLE = 4'hA;
	localparam logic [3:0] C0_SEL_HF = 4'h5;
	localparam logic [3:0] C0_SEL_TCK = 4'hA;
	localparam logic [3:0] C1_SEL_PLL = 4'h0;
	localparam logic [3:0] C1_SEL_LF = 4'h2;
	localparam logic [3:0] C1_SEL_HF = 4'h3;
	localparam logic [3:0] C1_SEL_EXT1 = 4'h5;
	localparam logic [3:0] C1_SEL_EXT2 = 4'h6;
	localparam logic [3:0] C1_SEL_PER_LO = 4'h8;
	// comparator states
	typedef enum logic [1:0] {
		CCM_IDLE = 2'b00,
		CCM_RUN = 2'b01,
		CCM_DONE = 2'b10,
		CCM_ERR = 2'b11
	} ccm_state_t;
endpackage : ccm_pkg

// ---- rtl/ccm_dcc.sv ----
// Purpose: one dual clock comparator: reference window versus clock under test
// Assumes: ref_tick_i and test_tick_i are one-cycle pulses, one per source rising edge
// Notes: an error freezes both counters until reload, and is held until clear or reload
`timescale 1ns/1ps
`default_nettype none
module ccm_dcc
	import ccm_pkg::*;
#(
	parameter int unsigned SEED_W = CCM_SEED_W
) (
	input wire logic mclk_i, // system clock
	input wire logic rst_n_i, // async reset, active low
	input wire logic start_i, // load seeds and start, pulse
	input wire logic clr_i, // clear error, pulse
	input wire logic [SEED_W-1:0] seed0_i, // reference count seed
	input wire logic [SEED_W-1:0] seed1_i, // test count seed
	input wire logic ref_tick_i, // reference edge pulse
	input wire logic test_tick_i, // test clock edge pulse
	output logic win_o, // counting window open
	output logic pulse_o, // counter 1 reached zero
	output logic err_o // mismatch error
);
	// ==========================================================================
	// counters and state
	ccm_state_t state_q, state_d;
	logic [SEED_W-1:0] cnt0_q, cnt0_d, cnt1_q, cnt1_d;
	logic win_q, win_d, pulse_q, pulse_d, err_q, err_d;

	// next-state computation
	always_comb begin
		state_d = state_q;
		cnt0_d = cnt0_q;
		cnt1_d = cnt1_q;
		pulse_d = 1'b0;
		err_d = err_q;
		if (start_i) begin
			// both counters load together and start together
			cnt0_d = seed0_i;
			cnt1_d = seed1_i;
			err_d = 1'b0; // reload clears error
			state_d = CCM_RUN;
		end else begin
			case (state_q)
				CCM_RUN: begin
					if (test_tick_i && cnt1_q != '0) begin
						cnt1_d = cnt1_q - 1'b1;
						pulse_d = (cnt1_q == SEED_W'(1)); // one-cycle pulse
					end
					if (ref_tick_i && cnt0_q != '0) begin
						cnt0_d = cnt0_q - 1'b1;
					end
					// window ends when counter 0 has counted its pulses
					if (cnt0_d == '0) begin
						if (cnt1_d != '0) begin
							state_d = CCM_ERR;
							err_d = 1'b1;
						end else begin
							state_d = CCM_DONE;
						end
					end
				end
				CCM_ERR: begin
					// counters frozen, error held
					if (clr_i) begin
						err_d = 1'b0;
						state_d = CCM_IDLE;
					end
				end
				default: begin
					if (clr_i) begin
						state_d = CCM_IDLE;
					end
				end
			endcase
		end
		win_d = (state_d == CCM_RUN);
	end

	// registers
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= CCM_IDLE;
			cnt0_q <= '0;
			cnt1_q <= '0;
			win_q <= 1'b0;
			pulse_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt0_q <= cnt0_d;
			cnt1_q <= cnt1_d;
			win_q <= win_d;
			pulse_q <= pulse_d;
			err_q <= err_d;
		end
	end

	assign win_o = win_q;
	assign pulse_o = pulse_q;
	assign err_o = err_q;

	// ==========================================================================
	// checks
	sequence s_err_set;
		$rose(err_q);
	endsequence

	chk_pulse_single: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		pulse_q |=> !pulse_q)
		else $error("counter 1 pulse longer than one cycle");
	chk_err_window: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		s_err_set |-> $past(win_q) && !win_q && $past(cnt1_q) != '0)
		else $error("error raised outside window end");
	chk_err_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		err_q && !clr_i && !start_i |=> err_q && $stable(cnt0_q) && $stable(cnt1_q))
		else $error("error not held or counters moved");
	chk_load_seeds: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		start_i |=> win_q && cnt0_q == $past(seed0_i)
			&& cnt1_q == $past(seed1_i) && !err_q)
		else $error("seeds not loaded together");
endmodule : ccm_dcc
`default_nettype wire

// ---- rtl/ccm_top.sv ----
// Purpose: oscillator failure detector plus two dual clock comparators
// Assumes: monitored clocks are pins well below half the system clock rate
// Notes: clock switching is signalled by limp_mode_o, the mux sits outside
// ==========================================================================
// Overview of operation
// - oscillator leaving its valid window sets the fail flag, status bit 0
// - on failure, domains fed by the oscillator switch to internal high-freq osc
// - oscillator valid only when strictly between quarter and four times internal osc
// - two down-counters, reference and test clock, load seeds and start together
// - counter 0 makes the counting window after its programmed reference pulses
// - counter 1 emits a one-cycle pulse after its programmed test pulses
// - error when counter 1 has not reached zero before the window ends
// - a mismatch drives an error signal used as a cpu interrupt request
// - comparator 1 counter 0: 0x5 internal high-freq, 0xA test clock, else oscillator
// - comparator 1 counter 1: keyed source map, timer channel 31 without key
// - comparator 2 counter 0: 0xA test clock, else oscillator
// - comparator 2 counter 1: timer channel 0 without key, 0x8-0xF peripheral clock
`timescale 1ns/1ps
`default_nettype none
module ccm_top
	import ccm_pkg::*;
#(
	parameter int unsigned SEED_W = CCM_SEED_W,
	parameter int unsigned DET_WIN = CCM_DET_WIN
) (
	input wire logic mclk_i, // system clock 50 MHz
	input wire logic rst_n_i, // async reset, active low
	input wire logic osc_in_clock_i, // external oscillator pin
	input wire logic high_freq_internal_osc_i, // internal high-freq osc
	input wire logic low_freq_internal_osc_i, // internal low-freq osc
	input wire logic tck_i, // test clock
	input wire logic pll_free_i, // free-running pll output
	input wire logic external_clock_input_1_i, // external clock 1
	input wire logic external_clock_input_2_i, // external clock 2
	input wire logic peripheral_clock_i, // peripheral clock
	input wire logic timer1_channel_31_i, // timer 1 channel 31
	input wire logic timer2_channel_0_i, // timer 2 channel 0
	input wire logic oscillator_fail_flag_clr_i, // clear fail flag, pulse
	input wire logic [3:0] dcc1_src0_i, // comparator 1 counter 0 source
	input wire logic [3:0] dcc1_key_i, // comparator 1 counter 1 key
	input wire logic [3:0] dcc1_src1_i, // comparator 1 counter 1 source
	input wire logic [SEED_W-1:0] dcc1_seed0_i, // comparator 1 seed 0
	input wire logic [SEED_W-1:0] dcc1_seed1_i, // comparator 1 seed 1
	input wire logic dcc1_start_i, // comparator 1 load and start
	input wire logic dcc1_clr_i, // comparator 1 clear error
	input wire logic [3:0] dcc2_src0_i, // comparator 2 counter 0 source
	input wire logic [3:0] dcc2_key_i, // comparator 2 counter 1 key
	input wire logic [3:0] dcc2_src1_i, // comparator 2 counter 1 source
	input wire logic [SEED_W-1:0] dcc2_seed0_i, // comparator 2 seed 0
	input wire logic [SEED_W-1:0] dcc2_seed1_i, // comparator 2 seed 1
	input wire logic dcc2_start_i, // comparator 2 load and start
	input wire logic dcc2_clr_i, // comparator 2 clear error
	output logic oscillator_fail_flag_o, // status bit 0, sticky
	output logic limp_mode_o, // oscillator domains on internal osc
	output logic dcc1_win_o, // comparator 1 window open
	output logic dcc1_pulse_o, // comparator 1 counter 1 done
	output logic dcc1_err_o, // comparator 1 error
	output logic dcc2_win_o, // comparator 2 window open
	output logic dcc2_pulse_o, // comparator 2 counter 1 done
	output logic dcc2_err_o, // comparator 2 error
	output logic dcc_irq_o // error interrupt to cpu
);
	// ==========================================================================
	// pin synchronisers and edge detection
	logic [CCM_NSRC-1:0] pins, sync1_q, sync2_q, sync3_q, tick;

	assign pins = {timer2_channel_0_i, timer1_channel_31_i, peripheral_clock_i,
		external_clock_input_2_i, external_clock_input_1_i, pll_free_i, tck_i,
		low_freq_internal_osc_i, high_freq_internal_osc_i, osc_in_clock_i};

	// two-flop sync, third flop only for edge detect
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	assign tick = sync2_q & ~sync3_q;

	// ==========================================================================
	// source decoding
	function automatic logic [3:0] sel_c0(input logic [3:0] f, input logic hf_ok);
		if (hf_ok && f == C0_SEL_HF) begin
			sel_c0 = SRC_HF;
		end else if (f == C0_SEL_TCK) begin
			sel_c0 = SRC_TCK;
		end else begin
			sel_c0 = SRC_OSC;
		end
	endfunction : sel_c0

	function automatic logic [3:0] sel_c1(input logic [3:0] key, input logic [3:0] f,
		input logic first);
		if (key != KEY_ENABLE) begin
			sel_c1 = first ? SRC_TM1 : SRC_TM2;
		end else if (f >= C1_SEL_PER_LO) begin
			sel_c1 = SRC_PER;
		end else if (!first) begin
			sel_c1 = SRC_NONE; // reserved
		end else if (f == C1_SEL_PLL) begin
			sel_c1 = SRC_PLL;
		end else if (f == C1_SEL_LF) begin
			sel_c1 = SRC_LF;
		end else if (f == C1_SEL_HF) begin
			sel_c1 = SRC_HF;
		end else if (f == C1_SEL_EXT1) begin
			sel_c1 = SRC_EXT1;
		end else if (f == C1_SEL_EXT2) begin
			sel_c1 = SRC_EXT2;
		end else begin
			sel_c1 = SRC_NONE; // reserved codes never tick
		end
	endfunction : sel_c1

	function automatic logic pick(input logic [CCM_NSRC-1:0] t, input logic [3:0] s);
		pick = (s < 4'(CCM_NSRC)) ? t[s] : 1'b0;
	endfunction : pick

	logic d1_ref, d1_test, d2_ref, d2_test;

	assign d1_ref = pick(tick, sel_c0(dcc1_src0_i, 1'b1));
	assign d1_test = pick(tick, sel_c1(dcc1_key_i, dcc1_src1_i, 1'b1));
	assign d2_ref = pick(tick, sel_c0(dcc2_src0_i, 1'b0));
	assign d2_test = pick(tick, sel_c1(dcc2_key_i, dcc2_src1_i, 1'b0));

	// ==========================================================================
	// comparators
	ccm_dcc #(.SEED_W(SEED_W)) u_dcc1 (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.start_i(dcc1_start_i),
		.clr_i(dcc1_clr_i),
		.seed0_i(dcc1_seed0_i),
		.seed1_i(dcc1_seed1_i),
		.ref_tick_i(d1_ref),
		.test_tick_i(d1_test),
		.win_o(dcc1_win_o),
		.pulse_o(dcc1_pulse_o),
		.err_o(dcc1_err_o)
	);

	ccm_dcc #(.SEED_W(SEED_W)) u_dcc2 (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.start_i(dcc2_start_i),
		.clr_i(dcc2_clr_i),
		.seed0_i(dcc2_seed0_i),
		.seed1_i(dcc2_seed1_i),
		.ref_tick_i(d2_ref),
		.test_tick_i(d2_test),
		.win_o(dcc2_win_o),
		.pulse_o(dcc2_pulse_o),
		.err_o(dcc2_err_o)
	);

	// ==========================================================================
	// oscillator failure detector and interrupt
	logic [CCM_DET_CW-1:0] win_cnt_q, win_cnt_d, osc_cnt_q, osc_cnt_d;
	logic fail_q, fail_d, limp_q, limp_d, irq_q, irq_d;
	logic win_end, osc_bad;

	assign win_end = tick[SRC_HF] && (win_cnt_q == CCM_DET_CW'(DET_WIN - 1));
	// strict window on edge counts over DET_WIN internal edges
	assign osc_bad = (CCM_DET_CW'(CCM_WIN_FACTOR) * osc_cnt_q <= CCM_DET_CW'(DET_WIN))
		|| (osc_cnt_q >= CCM_DET_CW'(DET_WIN * CCM_WIN_FACTOR));

	// next-state for detector
	always_comb begin
		win_cnt_d = win_cnt_q;
		osc_cnt_d = osc_cnt_q;
		if (tick[SRC_OSC] && osc_cnt_q != '1) begin
			osc_cnt_d = osc_cnt_q + 1'b1;
		end
		if (win_end) begin
			win_cnt_d = '0;
			osc_cnt_d = '0;
		end else if (tick[SRC_HF]) begin
			win_cnt_d = win_cnt_q + 1'b1;
		end
		// software clear loses to a new failure; stays after recovery
		fail_d = (fail_q && !oscillator_fail_flag_clr_i) || (win_end && osc_bad);
		limp_d = fail_d; // move oscillator domains to internal osc
		irq_d = dcc1_err_o || dcc2_err_o;
	end

	// detector registers
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			win_cnt_q <= '0;
			osc_cnt_q <= '0;
			fail_q <= 1'b0;
			limp_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			win_cnt_q <= win_cnt_d;
			osc_cnt_q <= osc_cnt_d;
			fail_q <= fail_d;
			limp_q <= limp_d;
			irq_q <= irq_d;
		end
	end

	assign oscillator_fail_flag_o = fail_q;
	assign limp_mode_o = limp_q;
	assign dcc_irq_o = irq_q;

	// ==========================================================================
	// checks
	chk_fail_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		win_end && osc_bad |=> fail_q)
		else $error("oscillator failure not flagged");
	chk_fail_sticky: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		fail_q && !oscillator_fail_flag_clr_i |=> fail_q)
		else $error("fail flag dropped without clear");
	chk_fail_cause: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(fail_q) |-> $past(win_end) && $past(osc_bad))
		else $error("fail flag rose without bad window");
	chk_limp_switch: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(fail_q) |-> limp_q)
		else $error("limp mode not entered on failure");
	chk_irq_error: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(dcc1_err_o || dcc2_err_o) |=> dcc_irq_o)
		else $error("comparator error did not raise interrupt");
endmodule : ccm_top
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench for the oscillator failure detector and both comparators
// Assumes: monitored clock pins are made here from mclk, each high and low >= 2 cycles
// Notes: both comparators share source fields and seeds, only start and clear differ
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ccm_pkg::*;
	// ==========================================================================
	// clock, reset and stimulus signals
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [9:0] pin = 10'h000;
	int half_c[10] = '{12, 10, 50, 5, 3, 3, 3, 4, 3, 3};
	int cnt_c[10] = '{default: 0};
	bit osc_run = 1'b1;
	logic oscillator_fail_flag_clr_i = 1'b0;
	logic [1:0] st = 2'h0;
	logic [1:0] cl = 2'h0;
	logic [3:0] s0r = 4'h0;
	logic [3:0] kr = 4'h0;
	logic [3:0] s1r = 4'h0;
	logic [15:0] seed0r = 16'h0000;
	logic [15:0] seed1r = 16'h0000;
	logic oscillator_fail_flag_o;
	logic limp_mode_o;
	logic dcc_irq_o;
	wire logic [1:0] win;
	wire logic [1:0] pls;
	wire logic [1:0] err;
	int failures = 0;
	int samples_checked = 0;
	int cyc = 0;

	// system clock, 20 ns period
	initial begin
		forever #10 mclk_i = ~mclk_i;
	end

	// monitored pins toggle a fixed delay after each edge; a stopped oscillator rests low
	always @(posedge mclk_i) begin
		#1;
		for (int i = 0; i < 10; i++) begin
			if (cnt_c[i] >= half_c[i] - 1) begin
				cnt_c[i] = 0;
				pin[i] = ~pin[i] & (i != 0 || osc_run);
			end else begin
				cnt_c[i]++;
			end
		end
	end

	// ==========================================================================
	// device under test
	ccm_top dut_u (
		.mclk_i, .rst_n_i, .osc_in_clock_i(pin[0]), .high_freq_internal_osc_i(pin[1]),
		.low_freq_internal_osc_i(pin[2]), .tck_i(pin[3]), .pll_free_i(pin[4]),
		.external_clock_input_1_i(pin[5]), .external_clock_input_2_i(pin[6]),
		.peripheral_clock_i(pin[7]), .timer1_channel_31_i(pin[8]),
		.timer2_channel_0_i(pin[9]), .oscillator_fail_flag_clr_i,
		.dcc1_src0_i(s0r), .dcc1_key_i(kr), .dcc1_src1_i(s1r), .dcc1_seed0_i(seed0r),
		.dcc1_seed1_i(seed1r), .dcc1_start_i(st[0]), .dcc1_clr_i(cl[0]),
		.dcc2_src0_i(s0r), .dcc2_key_i(kr), .dcc2_src1_i(s1r), .dcc2_seed0_i(seed0r),
		.dcc2_seed1_i(seed1r), .dcc2_start_i(st[1]), .dcc2_clr_i(cl[1]),
		.oscillator_fail_flag_o, .limp_mode_o,
		.dcc1_win_o(win[0]), .dcc1_pulse_o(pls[0]), .dcc1_err_o(err[0]),
		.dcc2_win_o(win[1]), .dcc2_pulse_o(pls[1]), .dcc2_err_o(err[1]), .dcc_irq_o
	);

	// ==========================================================================
	// shared helpers
	task automatic tick;
		@(posedge mclk_i);
		#1;
	endtask : tick

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task automatic end_of_test;
		$display("failures %0d samples_checked %0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test

	// hang guard: the whole run needs well under this many cycles
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 40000) begin
			failures++;
			end_of_test();
		end
	end

	// ==========================================================================
	// scenario: one comparator run, window length judged against the reference period
	task automatic run_dcc(input int u, input logic [3:0] s0, input logic [3:0] k,
			input logic [3:0] s1, input int n1, input int rp, input bit bad);
		int np;
		int w;
		np = 0;
		w = 0;
		s0r = s0;
		kr = k;
		s1r = s1;
		seed0r = 16'h0008;
		seed1r = 16'(n1);
		st[u] = 1'b1;
		tick();
		st[u] = 1'b0;
		chk(16'(win[u]), 16'h0001);
		do begin
			tick();
			np += int'(pls[u] === 1'b1);
			w++;
		end while (win[u] === 1'b1 && w < 2000);
		chk(16'(w >= 7 * rp && w <= 8 * rp + 2), 16'h0001);
		chk(16'(np), bad ? 16'h0000 : 16'h0001);
		chk(16'(err[u]), 16'(bad));
		tick();
		chk(16'(dcc_irq_o), 16'(bad));
		repeat (3) tick();
		chk({15'h0000, err[u]}, 16'(bad));
		chk({15'h0000, win[u]}, 16'h0000);
		cl[u] = 1'b1;
		tick();
		cl[u] = 1'b0;
		chk(16'(err[u]), 16'h0000);
		tick();
		chk(16'(dcc_irq_o), 16'h0000);
	endtask : run_dcc

	// scenario: oscillator at a given half period (0 = stopped), flag judged after a clear
	task automatic det(input int half, input bit bad);
		osc_run = (half != 0);
		if (half != 0) begin
			half_c[0] = half;
		end
		repeat (700) tick();
		oscillator_fail_flag_clr_i = 1'b1;
		tick();
		oscillator_fail_flag_clr_i = 1'b0;
		repeat (700) tick();
		chk(16'(oscillator_fail_flag_o), 16'(bad));
		chk(16'(limp_mode_o), 16'(bad));
	endtask : det

	// ==========================================================================
	// main sequence
	initial begin
		repeat (12) @(posedge mclk_i);
		#1;
		rst_n_i = 1'b1;
		chk({7'h00, oscillator_fail_flag_o, limp_mode_o, win, pls, err, dcc_irq_o}, 16'h0000);
		repeat (20) tick();
		// comparator 1: reference codes 5 (hf, 20), A (tck, 10), others (osc, 24)
		run_dcc(0, 4'h5, 4'hA, 4'h0, 2, 20, 1'b0);
		run_dcc(0, 4'h5, 4'hA, 4'h2, 1, 20, 1'b0);
		run_dcc(0, 4'hA, 4'hA, 4'h3, 2, 10, 1'b0);
		run_dcc(0, 4'h0, 4'hA, 4'h5, 2, 24, 1'b0);
		run_dcc(0, 4'h7, 4'hA, 4'h6, 2, 24, 1'b0);
		run_dcc(0, 4'h5, 4'hA, 4'h8, 2, 20, 1'b0);
		run_dcc(0, 4'h5, 4'hA, 4'hF, 2, 20, 1'b0);
		run_dcc(0, 4'h5, 4'h3, 4'h1, 2, 20, 1'b0);
		run_dcc(0, 4'h5, 4'hA, 4'h1, 2, 20, 1'b1);
		run_dcc(0, 4'h5, 4'hA, 4'h4, 2, 20, 1'b1);
		run_dcc(0, 4'h5, 4'hA, 4'h7, 2, 20, 1'b1);
		run_dcc(0, 4'h5, 4'hA, 4'h0, 60, 20, 1'b1);
		// comparator 2: A is tck, 5 is not special there
		run_dcc(1, 4'hA, 4'hA, 4'h8, 2, 10, 1'b0);
		run_dcc(1, 4'h5, 4'hA, 4'hF, 2, 24, 1'b0);
		run_dcc(1, 4'h0, 4'h2, 4'h0, 2, 24, 1'b0);
		run_dcc(1, 4'h0, 4'hA, 4'h0, 2, 24, 1'b1);
		run_dcc(1, 4'h0, 4'hA, 4'h7, 2, 24, 1'b1);
		// detector: inside, near both edges, outside both edges, stopped
		det(12, 1'b0);
		det(30, 1'b0);
		det(3, 1'b0);
		det(50, 1'b1);
		det(2, 1'b1);
		det(0, 1'b1);
		// recovery leaves the flag set until software clears it
		osc_run = 1'b1;
		half_c[0] = 12;
		repeat (700) tick();
		chk(16'(oscillator_fail_flag_o), 16'h0001);
		oscillator_fail_flag_clr_i = 1'b1;
		tick();
		oscillator_fail_flag_clr_i = 1'b0;
		chk(16'(oscillator_fail_flag_o), 16'h0000);
		chk(16'(limp_mode_o), 16'h0000);
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
